/* File: core/cbsa_map.vh */
// constants for the branch, stack and extended arithmetic decode block
// assumes an 8-bit core with 12-bit register addresses and 16-bit program counter
`ifndef CBSA_MAP_VH
`define CBSA_MAP_VH
// ****************************************************************
// opcodes (low nibble for the row families)
// ****************************************************************
`define CBSA_LO_DBNZ 4'ha
`define CBSA_LO_RJMP 4'hb
`define CBSA_LO_DJMP 4'hd
`define CBSA_OP_INTERRUPT_RETURN 8'hbf
`define CBSA_OP_XPOP 8'hd8
`define CBSA_OP_CBLK 8'hc3
`define CBSA_OP_EBLK 8'h83
`define CBSA_OP_XSBC_ER 8'h38
`define CBSA_OP_XSBC_IM 8'h39
`define CBSA_OP_XADC_ER 8'h18
`define CBSA_OP_XADC_IM 8'h19
`define CBSA_OP_XCPC_ER 8'h1f
`define CBSA_OP_XCMT_ER 8'h68
`define CBSA_OP_XCMT_IM 8'h69
// ****************************************************************
// execute cycle counts
// ****************************************************************
`define CBSA_EX_DBNZ 3'h3
`define CBSA_EX_RJMP 3'h2
`define CBSA_EX_DJMP 3'h2
`define CBSA_EX_INTERRUPT_RETURN 3'h5
`define CBSA_EX_XPOP 3'h2
`define CBSA_EX_XALU 3'h3
`define CBSA_EX_BLK 3'h2
// ****************************************************************
// flag bit positions and reset values
// ****************************************************************
`define CBSA_FL_C 7
`define CBSA_FL_Z 6
`define CBSA_FL_S 5
`define CBSA_FL_V 4
`define CBSA_FL_D 3
`define CBSA_FL_H 2
`define CBSA_GIE_BIT 7
`define CBSA_RST_PC 16'h0000
`define CBSA_RST_SP 12'h000
`define CBSA_RST_FL 8'h00
`endif

/* File: core/cbsa_decode.v */
// decode and execute of jumps, loop branch, interrupt return, extended pop,
// block moves and extended-address arithmetic and mask tests
// assumes fetch presents a whole instruction (opcode plus up to three operand
// bytes) with a valid strobe, and memories answer reads in the same cycle
`timescale 1ns/1ps
`include "cbsa_map.vh"

// Contract
// - constant block move copies a byte between program memory and a register, then bumps both pointers.
// - external block move copies a byte between data memory and a register, then bumps both addresses.
// - decrement-branch-nonzero decrements its register and adds the displacement to pc if nonzero, in three execute cycles.
// - conditional relative jump adds the displacement to pc only when the condition holds, in two execute cycles.
// - conditional direct jump loads pc with the address only when the condition holds, in two execute cycles.
// - interrupt return pops flags then pc, advancing sp by one then two, sets interrupt enable, in five cycles (the sequencer takes four).
// - extended pop reads the byte at sp into a 12-bit addressed register, bumps sp, keeps flags, in two cycles.
// - extended subtract-borrow computes dst minus src minus carry, sets all six flags, in three cycles.
// - extended add-carry adds src and carry into dst using 12-bit register addresses.
// - extended compare-carry sets flags from dst minus src minus carry without writing dst.
// - extended complement-mask test tests the complemented dst against the src mask.
module cbsa_decode (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // instruction from fetch
  input wire instr_valid,
  input wire [7:0] instr_op,
  input wire [7:0] instr_b1,
  input wire [7:0] instr_b2,
  input wire [7:0] instr_b3,
  output wire instr_ready,
  // register file, 12-bit address
  output reg [11:0] rf_addr_ff,
  output reg [7:0] rf_wdata_ff,
  output reg rf_we_ff,
  input wire [7:0] rf_rdata,
  // program memory and data memory
  output reg [15:0] mem_addr_ff,
  output reg [7:0] mem_wdata_ff,
  output reg mem_we_ff,
  output reg mem_prog_ff,
  input wire [7:0] mem_rdata,
  // core state
  output reg [15:0] pc_ff,
  output reg [11:0] sp_ff,
  output reg [7:0] flags_ff,
  output reg irq_enable_ff,
  output reg busy_ff
);
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_RD1 = 8'h02;
  localparam [7:0] ST_RD2 = 8'h04;
  localparam [7:0] ST_PTR_LO = 8'h08;
  localparam [7:0] ST_WR = 8'h10;
  localparam [7:0] ST_WR2 = 8'h20;
  localparam [7:0] ST_DONE = 8'h40;
  localparam [7:0] ST_PTR_HI = 8'h80;
  localparam [3:0] K_DBNZ = 4'h1;
  localparam [3:0] K_RJMP = 4'h2;
  localparam [3:0] K_DJMP = 4'h3;
  localparam [3:0] K_INTERRUPT_RETURN = 4'h4;
  localparam [3:0] K_XPOP = 4'h5;
  localparam [3:0] K_CBLK = 4'h6;
  localparam [3:0] K_EBLK = 4'h7;
  localparam [3:0] K_XALU = 4'h8;
  localparam [3:0] K_NONE = 4'h0;
  localparam [1:0] A_SBC = 2'h0;
  localparam [1:0] A_ADC = 2'h1;
  localparam [1:0] A_CPC = 2'h2;
  localparam [1:0] A_TCM = 2'h3;
  reg [7:0] st_ff;
  reg [3:0] kind_ff;
  reg [1:0] alu_ff;
  reg imm_ff;
  reg [7:0] op_ff, b1_ff, b2_ff, b3_ff;
  reg [7:0] tmp_ff, src_ff;
  // ****************************************************************
  // classify the opcode
  // ****************************************************************
  reg [3:0] kind_d;
  reg [1:0] alu_d;
  reg imm_d;
  always @* begin
    kind_d = K_NONE;
    alu_d = A_SBC;
    imm_d = 1'b0;
    if (instr_op == `CBSA_OP_INTERRUPT_RETURN) begin
      kind_d = K_INTERRUPT_RETURN;
    end else if (instr_op == `CBSA_OP_XPOP) begin
      kind_d = K_XPOP;
    end else if (instr_op == `CBSA_OP_CBLK) begin
      kind_d = K_CBLK;
    end else if (instr_op == `CBSA_OP_EBLK) begin
      kind_d = K_EBLK;
    end else if (instr_op == `CBSA_OP_XSBC_ER || instr_op == `CBSA_OP_XSBC_IM) begin
      kind_d = K_XALU;
      imm_d = instr_op[0];
    end else if (instr_op == `CBSA_OP_XADC_ER || instr_op == `CBSA_OP_XADC_IM) begin
      kind_d = K_XALU;
      alu_d = A_ADC;
      imm_d = instr_op[0];
    end else if (instr_op == `CBSA_OP_XCPC_ER) begin
      kind_d = K_XALU;
      alu_d = A_CPC;
    end else if (instr_op == `CBSA_OP_XCMT_ER || instr_op == `CBSA_OP_XCMT_IM) begin
      kind_d = K_XALU;
      alu_d = A_TCM;
      imm_d = instr_op[0];
    end else if (instr_op[3:0] == `CBSA_LO_DBNZ) begin
      kind_d = K_DBNZ;
    end else if (instr_op[3:0] == `CBSA_LO_RJMP) begin
      // high nibble 8 is the always-true condition, not a separate row
      kind_d = K_RJMP;
    end else if (instr_op[3:0] == `CBSA_LO_DJMP) begin
      kind_d = K_DJMP;
    end
  end
  // ****************************************************************
  // condition code from the opcode high nibble
  // ****************************************************************
  wire fc = flags_ff[`CBSA_FL_C];
  wire fz = flags_ff[`CBSA_FL_Z], fs = flags_ff[`CBSA_FL_S], fv = flags_ff[`CBSA_FL_V];
  reg cc_base;
  always @* begin
    case (op_ff[6:4])
      3'h0: cc_base = 1'b0;
      3'h1: cc_base = fs ^ fv;
      3'h2: cc_base = fz | (fs ^ fv);
      3'h3: cc_base = fc | fz;
      3'h4: cc_base = fv;
      3'h5: cc_base = fs;
      3'h6: cc_base = fz;
      default: cc_base = fc;
    endcase
  end
  wire cc_true = cc_base ^ op_ff[7];
  // ****************************************************************
  // extended arithmetic
  // ****************************************************************
  wire [7:0] dst_v = rf_rdata;
  wire [7:0] src_v = imm_ff ? b1_ff : src_ff;
  wire [8:0] sub_r = {1'b0, dst_v} - {1'b0, src_v} - {8'h00, fc};
  wire [8:0] add_r = {1'b0, dst_v} + {1'b0, src_v} + {8'h00, fc};
  wire [4:0] sub_h = {1'b0, dst_v[3:0]} - {1'b0, src_v[3:0]} - {4'h0, fc};
  wire [4:0] add_h = {1'b0, dst_v[3:0]} + {1'b0, src_v[3:0]} + {4'h0, fc};
  wire [7:0] tcm_r = (~dst_v) & src_v;
  wire sub_v = (dst_v[7] ^ src_v[7]) & (dst_v[7] ^ sub_r[7]);
  wire add_v = ~(dst_v[7] ^ src_v[7]) & (dst_v[7] ^ add_r[7]);
  wire [15:0] rel_pc = pc_ff + {{8{b1_ff[7]}}, b1_ff};
  wire [7:0] dec_r = rf_rdata - 8'h01;
  reg [7:0] alu_flags;
  reg [7:0] alu_res;
  reg alu_wr;
  always @* begin
    alu_flags = flags_ff;
    alu_res = sub_r[7:0];
    alu_wr = 1'b1;
    case (alu_ff)
      A_ADC: begin
        alu_res = add_r[7:0];
        alu_flags[`CBSA_FL_C] = add_r[8];
        alu_flags[`CBSA_FL_Z] = (add_r[7:0] == 8'h00);
        alu_flags[`CBSA_FL_S] = add_r[7];
        alu_flags[`CBSA_FL_V] = add_v;
        alu_flags[`CBSA_FL_D] = 1'b0;
        alu_flags[`CBSA_FL_H] = add_h[4];
      end
      A_TCM: begin
        alu_res = tcm_r;
        alu_wr = 1'b0;
        alu_flags[`CBSA_FL_Z] = (tcm_r == 8'h00);
        alu_flags[`CBSA_FL_S] = tcm_r[7];
        alu_flags[`CBSA_FL_V] = 1'b0;
      end
      default: begin
        // sbc and cpc share the borrow path; cpc drops the write
        alu_wr = (alu_ff == A_SBC);
        alu_flags[`CBSA_FL_C] = sub_r[8];
        alu_flags[`CBSA_FL_Z] = (sub_r[7:0] == 8'h00);
        alu_flags[`CBSA_FL_S] = sub_r[7];
        alu_flags[`CBSA_FL_V] = sub_v;
        alu_flags[`CBSA_FL_D] = 1'b1;
        alu_flags[`CBSA_FL_H] = sub_h[4];
      end
    endcase
  end
  assign instr_ready = st_ff[0];
  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= ST_IDLE;
      kind_ff <= K_NONE;
      alu_ff <= A_SBC;
      imm_ff <= 1'b0;
      op_ff <= 8'h00;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      b3_ff <= 8'h00;
      tmp_ff <= 8'h00;
      src_ff <= 8'h00;
      rf_addr_ff <= 12'h000;
      rf_wdata_ff <= 8'h00;
      rf_we_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_we_ff <= 1'b0;
      mem_prog_ff <= 1'b0;
      pc_ff <= `CBSA_RST_PC;
      sp_ff <= `CBSA_RST_SP;
      flags_ff <= `CBSA_RST_FL;
      irq_enable_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      rf_we_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (instr_valid && kind_d != K_NONE) begin
            kind_ff <= kind_d;
            alu_ff <= alu_d;
            imm_ff <= imm_d;
            op_ff <= instr_op;
            b1_ff <= instr_b1;
            b2_ff <= instr_b2;
            b3_ff <= instr_b3;
            busy_ff <= 1'b1;
            st_ff <= ST_RD1;
            // working register of the loop branch is the opcode high nibble
            rf_addr_ff <= (kind_d == K_DBNZ) ? {8'h00, instr_op[7:4]} :
              (kind_d == K_XPOP) ? {instr_b1, instr_b2[7:4]} :
              (kind_d == K_XALU) ? {instr_b2[3:0], instr_b3} :
              {8'h00, instr_b1[3:0]};
            mem_addr_ff <= {4'h0, sp_ff};
          end
        end
        ST_RD1: begin
          st_ff <= ST_RD2;
          case (kind_ff)
            K_DBNZ: begin
              rf_wdata_ff <= dec_r;
              rf_we_ff <= 1'b1;
              tmp_ff <= dec_r;
            end
            K_RJMP: begin
              if (cc_true) pc_ff <= rel_pc;
              st_ff <= ST_DONE;
            end
            K_DJMP: begin
              if (cc_true) pc_ff <= {b1_ff, b2_ff};
              st_ff <= ST_DONE;
            end
            K_INTERRUPT_RETURN: begin
              flags_ff <= mem_rdata;
              mem_addr_ff <= {4'h0, sp_ff + 12'h001};
              sp_ff <= sp_ff + 12'h001;
            end
            K_XPOP: begin
              rf_wdata_ff <= mem_rdata;
              rf_we_ff <= 1'b1;
              sp_ff <= sp_ff + 12'h001;
              st_ff <= ST_DONE;
            end
            K_XALU: begin
              src_ff <= rf_rdata;
              rf_addr_ff <= {b1_ff, b2_ff[7:4]};
            end
            default: begin
              // block moves: pointer pair named by b1, target index register by b2
              tmp_ff <= rf_rdata;
              rf_addr_ff <= {8'h00, b1_ff[3:0] + 4'h1};
            end
          endcase
        end
        ST_RD2: begin
          st_ff <= ST_WR;
          case (kind_ff)
            K_DBNZ: begin
              if (tmp_ff != 8'h00) pc_ff <= rel_pc;
              st_ff <= ST_DONE;
            end
            K_INTERRUPT_RETURN: begin
              pc_ff[15:8] <= mem_rdata;
              mem_addr_ff <= {4'h0, sp_ff + 12'h001};
            end
            K_XALU: begin
              flags_ff <= alu_flags;
              rf_wdata_ff <= alu_res;
              rf_we_ff <= alu_wr;
              st_ff <= ST_DONE;
            end
            default: begin
              mem_addr_ff <= {tmp_ff, rf_rdata};
              mem_prog_ff <= (kind_ff == K_CBLK);
              rf_addr_ff <= {8'h00, b2_ff[3:0]};
            end
          endcase
        end
        ST_WR: begin
          st_ff <= ST_WR2;
          if (kind_ff == K_INTERRUPT_RETURN) begin
            pc_ff[7:0] <= mem_rdata;
            sp_ff <= sp_ff + 12'h002;
            irq_enable_ff <= 1'b1;
            st_ff <= ST_DONE;
          end else begin
            // register side indexed by the byte held in the second operand reg
            rf_addr_ff <= {4'h0, rf_rdata};
            rf_wdata_ff <= mem_rdata;
            rf_we_ff <= 1'b1;
            tmp_ff <= rf_rdata + 8'h01;
          end
        end
        ST_WR2: begin
          // bump both pointers once the byte has moved
          mem_addr_ff <= mem_addr_ff + 16'h0001;
          rf_addr_ff <= {8'h00, b2_ff[3:0]};
          rf_wdata_ff <= tmp_ff;
          rf_we_ff <= 1'b1;
          st_ff <= ST_PTR_LO;
        end
        ST_PTR_LO, ST_PTR_HI: begin
          // bumped pointer back to its pair, low byte first, so moves chain
          rf_addr_ff <= {8'h00, b1_ff[3:0] + {3'h0, st_ff[3]}};
          rf_wdata_ff <= st_ff[3] ? mem_addr_ff[7:0] : mem_addr_ff[15:8];
          rf_we_ff <= 1'b1;
          st_ff <= st_ff[3] ? ST_PTR_HI : ST_DONE;
        end
        default: begin
          busy_ff <= 1'b0;
          mem_prog_ff <= 1'b0;
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // cbsa_decode

/* File: verification/cbsa_far_model.sv */
// register file and program/data memory facing the decode block
// assumes reads are combinational from the address and writes land on the clock edge
`timescale 1ns/1ps
module cbsa_far_model (
  // clock
  input wire ref_clk,
  // register file
  input wire [11:0] rf_addr,
  input wire [7:0] rf_wdata,
  input wire rf_we,
  output wire [7:0] rf_rdata,
  // memories
  input wire [15:0] mem_addr,
  input wire mem_prog,
  output wire [7:0] mem_rdata
);
  reg [7:0] rf_mem [0:4095];
  reg [7:0] pmem [0:65535];
  reg [7:0] dmem [0:65535];
  reg [11:0] last_addr_ff = 12'h000;
  reg [7:0] last_old_ff = 8'h00;
  integer wr_count = 0;
  // ****************************************************************
  // storage
  // ****************************************************************
  assign rf_rdata = rf_mem[rf_addr];
  assign mem_rdata = mem_prog ? pmem[mem_addr] : dmem[mem_addr];
  // old value kept so the bench can judge writes to unknown addresses
  always @(posedge ref_clk) begin
    if (rf_we) begin
      last_old_ff <= rf_mem[rf_addr];
      last_addr_ff <= rf_addr;
      rf_mem[rf_addr] <= rf_wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule // cbsa_far_model

/* File: verification/cbsa_decode_props.sv */
// assertions on the ports of the decode block
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ps
module cbsa_decode_props (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // instruction side
  input wire instr_valid,
  input wire [7:0] instr_op,
  input wire [7:0] instr_b1,
  input wire [7:0] instr_b2,
  input wire instr_ready,
  // results
  input wire [11:0] rf_addr_ff,
  input wire rf_we_ff,
  input wire [15:0] pc_ff,
  input wire [11:0] sp_ff,
  input wire [7:0] flags_ff,
  input wire irq_enable_ff
);
  wire tk = instr_valid & instr_ready;
  reg [15:0] rel_ff;
  reg [15:0] dir_ff;
  reg [11:0] sp0_ff;
  reg [11:0] dst_ff;
  // ****************************************************************
  // operands captured at the taking edge
  // ****************************************************************
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rel_ff <= 16'h0000;
      dir_ff <= 16'h0000;
      sp0_ff <= 12'h000;
      dst_ff <= 12'h000;
    end else if (tk) begin
      rel_ff <= pc_ff + {{8{instr_b1[7]}}, instr_b1};
      dir_ff <= {instr_b1, instr_b2};
      sp0_ff <= sp_ff;
      dst_ff <= {instr_b1, instr_b2[7:4]};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****************************************************************
  // properties
  // ****************************************************************
  AST_RJMP_TAKEN:
    assert property (tk && instr_op == 8'h8b |-> ##[1:4] pc_ff == rel_ff)
      else $error("relative jump target wrong");
  AST_JMP_FALSE:
    assert property (tk && (instr_op == 8'h0b || instr_op == 8'h0d) |=> $stable(pc_ff)[*3])
      else $error("false condition moved pc");
  AST_DJMP_TAKEN:
    assert property (tk && instr_op == 8'h8d |-> ##[1:4] pc_ff == dir_ff)
      else $error("direct jump target wrong");
  AST_INTERRUPT_RETURN_STATE:
    assert property (tk && instr_op == 8'hbf |-> ##[1:6] irq_enable_ff && sp_ff == sp0_ff + 12'h3)
      else $error("interrupt return sp or enable wrong");
  AST_XPOP_SP:
    assert property (tk && instr_op == 8'hd8 |-> ##[1:4] sp_ff == sp0_ff + 12'h1)
      else $error("extended pop sp wrong");
  AST_XPOP_FLAGS:
    assert property (tk && instr_op == 8'hd8 |=> $stable(flags_ff)[*3])
      else $error("extended pop changed flags");
  AST_XALU_WRITE:
    assert property (tk && (instr_op == 8'h38 || instr_op == 8'h18)
      |-> ##[1:5] rf_we_ff && rf_addr_ff == dst_ff) else $error("extended result not written");
  AST_TEST_NOWRITE:
    assert property (tk && (instr_op == 8'h1f || instr_op == 8'h68) |=> !rf_we_ff[*4])
      else $error("compare or mask test wrote a register");
endmodule // cbsa_decode_props

bind cbsa_decode cbsa_decode_props props (
  .ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid), .instr_op(instr_op),
  .instr_b1(instr_b1), .instr_b2(instr_b2), .instr_ready(instr_ready),
  .rf_addr_ff(rf_addr_ff), .rf_we_ff(rf_we_ff), .pc_ff(pc_ff), .sp_ff(sp_ff),
  .flags_ff(flags_ff), .irq_enable_ff(irq_enable_ff));

/* File: verification/testbench.sv */
// self-checking bench for the decode block with a register file and memory model
// assumes the design answers within twenty cycles of taking an instruction
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg instr_valid = 1'b0;
  reg [7:0] instr_op = 8'h00, instr_b1 = 8'h00, instr_b2 = 8'h00, instr_b3 = 8'h00;
  wire instr_ready, rf_we_ff, mem_we_ff, mem_prog_ff, irq_enable_ff, busy_ff;
  wire [11:0] rf_addr_ff, sp_ff;
  wire [7:0] rf_wdata_ff, rf_rdata, mem_wdata_ff, mem_rdata, flags_ff;
  wire [15:0] mem_addr_ff, pc_ff;
  integer n_errors = 0, n_tests = 0, cyc = 0, i, w0;
  always #50 ref_clk = ~ref_clk;
  cbsa_decode dut (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_b1(instr_b1), .instr_b2(instr_b2), .instr_b3(instr_b3),
    .instr_ready(instr_ready), .rf_addr_ff(rf_addr_ff), .rf_wdata_ff(rf_wdata_ff),
    .rf_we_ff(rf_we_ff), .rf_rdata(rf_rdata), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_we_ff(mem_we_ff), .mem_prog_ff(mem_prog_ff),
    .mem_rdata(mem_rdata), .pc_ff(pc_ff), .sp_ff(sp_ff), .flags_ff(flags_ff),
    .irq_enable_ff(irq_enable_ff), .busy_ff(busy_ff));
  cbsa_far_model far (.ref_clk(ref_clk), .rf_addr(rf_addr_ff), .rf_wdata(rf_wdata_ff),
    .rf_we(rf_we_ff), .rf_rdata(rf_rdata), .mem_addr(mem_addr_ff), .mem_prog(mem_prog_ff),
    .mem_rdata(mem_rdata));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task report_and_stop;
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop;
    end
  end
  // ends at a falling edge with the block idle again
  task issue(input [7:0] op, input [7:0] b1, input [7:0] b2, input [7:0] b3);
    integer k;
    @(posedge ref_clk);
    instr_op <= op;
    instr_b1 <= b1;
    instr_b2 <= b2;
    instr_b3 <= b3;
    instr_valid <= 1'b1;
    @(negedge ref_clk);
    while (instr_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    k = 0;
    @(negedge ref_clk);
    while (instr_ready !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_interrupt_return;
    issue(8'hbf, 8'h00, 8'h00, 8'h00);
    `CHK(flags_ff, 8'h50)
    `CHK(pc_ff, 16'h1234)
    `CHK(sp_ff, 12'h003)
    `CHK(irq_enable_ff, 1'b1)
  endtask
  task t_jumps;
    issue(8'h0b, 8'h05, 8'h00, 8'h00);
    `CHK(pc_ff, 16'h1234)
    issue(8'h8b, 8'hfe, 8'h00, 8'h00);
    `CHK(pc_ff, 16'h1232)
    issue(8'h0d, 8'hab, 8'hcd, 8'h00);
    `CHK(pc_ff, 16'h1232)
    issue(8'h8d, 8'hab, 8'hcd, 8'h00);
    `CHK(pc_ff, 16'habcd)
  endtask
  // same register twice: two down to one branches, one down to zero falls through
  task t_loop;
    issue(8'h1a, 8'h10, 8'h00, 8'h00);
    `CHK(far.rf_mem[far.last_addr_ff], 8'h01)
    `CHK(pc_ff, 16'habdd)
    issue(8'h1a, 8'h10, 8'h00, 8'h00);
    `CHK(far.rf_mem[far.last_addr_ff], 8'h00)
    `CHK(pc_ff, 16'habdd)
  endtask
  task t_xpop;
    issue(8'hd8, 8'h45, 8'h60, 8'h00);
    `CHK(far.rf_mem[12'h456], 8'h9c)
    `CHK(sp_ff, 12'h004)
    `CHK(flags_ff, 8'h50)
  endtask
  task t_alu;
    issue(8'h38, 8'h3a, 8'h53, 8'hb6);
    `CHK(far.rf_mem[12'h3a5], 8'hd0)
    `CHK(flags_ff[7:4], 4'ha)
    issue(8'h18, 8'h3c, 8'h73, 8'hd8);
    `CHK(far.rf_mem[12'h3c7], 8'h00)
    `CHK(flags_ff[7:4], 4'hc)
    w0 = far.wr_count;
    issue(8'h1f, 8'h3f, 8'h12, 8'h2a);
    // 0x10 minus 0x80 minus carry overflows the signed range, so v is set
    `CHK(flags_ff[7:4], 4'hb)
    issue(8'h68, 8'h3f, 8'h12, 8'h2a);
    `CHK(flags_ff[6:4], 3'h2)
    issue(8'h68, 8'h3c, 8'h73, 8'hd8);
    `CHK(flags_ff[6:4], 3'h4)
    issue(8'h69, 8'h3c, 8'h70, 8'h00);
    `CHK(flags_ff[6:4], 3'h0)
    `CHK(far.wr_count - w0, 0)
    issue(8'h39, 8'h10, 8'h3e, 8'h90);
    `CHK(far.rf_mem[far.last_addr_ff], far.last_old_ff - 8'h11)
    issue(8'h19, 8'h05, 8'h50, 8'h00);
    `CHK(far.rf_mem[12'h055], 8'h08)
  endtask
  // pointer pair r4/r5 and index in r6; the low pointer byte carries on the first move
  task t_blk;
    issue(8'hc3, 8'h04, 8'h06, 8'h00);
    `CHK(far.rf_mem[12'h040], 8'hff)
    `CHK(far.rf_mem[12'h004], 8'h13)
    `CHK(far.rf_mem[12'h005], 8'h00)
    `CHK(far.rf_mem[12'h006], 8'h41)
    issue(8'h83, 8'h04, 8'h06, 8'h00);
    `CHK(far.rf_mem[12'h041], 8'h5a)
    `CHK(far.rf_mem[12'h004], 8'h13)
    `CHK(far.rf_mem[12'h005], 8'h01)
    `CHK(far.rf_mem[12'h006], 8'h42)
    `CHK(busy_ff | mem_prog_ff, 1'b0)
  endtask
  task t_refuse;
    w0 = far.wr_count;
    issue(8'hff, 8'h12, 8'h34, 8'h56);
    `CHK(pc_ff, 16'habdd)
    `CHK(sp_ff, 12'h004)
    `CHK(far.wr_count - w0, 0)
  endtask
  initial begin
    for (i = 0; i < 65536; i++) begin
      far.pmem[i] = i[7:0];
      far.dmem[i] = 8'h00;
      if (i < 4096)
        far.rf_mem[i] = 8'h02;
    end
    far.dmem[0] = 8'h50;
    far.dmem[1] = 8'h12;
    far.dmem[2] = 8'h34;
    far.dmem[3] = 8'h9c;
    far.rf_mem[12'h3a5] = 8'h20;
    far.rf_mem[12'h3b6] = 8'h50;
    far.rf_mem[12'h3c7] = 8'hff;
    far.rf_mem[12'h3d8] = 8'h00;
    far.rf_mem[12'h3f1] = 8'h10;
    far.rf_mem[12'h22a] = 8'h80;
    far.rf_mem[12'h004] = 8'h12;
    far.rf_mem[12'h005] = 8'hff;
    far.rf_mem[12'h006] = 8'h40;
    far.dmem[16'h1300] = 8'h5a;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_interrupt_return;
    t_jumps;
    t_loop;
    t_xpop;
    t_alu;
    t_blk;
    t_refuse;
    report_and_stop;
  end
endmodule // testbench
